// ### soc_led_params.svh
// timing constants and reset defaults for the led display sequencer
`ifndef SOC_LED_PARAMS_SVH
`define SOC_LED_PARAMS_SVH
`define CLK_PERIOD_NS 20
`define TICK_PERIOD_NS 500000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define FLASH_HALF_RST 16'h0200
`define BLINK_HALF_RST 16'h0400
`define STEP_DELAY_RST 16'h0064
`define HOLD_TIME_S 4
`define HOLD_TICKS_RST 16'h1f40
`define SEG_COUNT 5
`endif

// ### soc_led_pkg.sv
// types shared by the led display sequencer
package soc_led_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RAMP = 2'b01,
      ST_HOLD = 2'b10
   } display_request_pin_state_t;
   typedef struct packed {
      logic [15:0] flash_half_period;
      logic [15:0] blink_half_period;
      logic [15:0] segment_step_delay;
      logic [15:0] display_hold_time;
   } led_timing_t;
   typedef struct packed {
      logic soc_source_select;
      logic charge_display_enable;
      logic alarm_flash_enable;
      logic remaining_capacity_alarm;
      logic discharging;
      logic charge_above_thresh;
   } led_status_t;
endpackage

// ### soc_led_display_sequencer.sv
// led bar sequencer: ramp, hold, flash and topmost-segment blink
//
// Functional notes
// - flash lit segments, period twice flash setting
// - flash only segments the charge level needs
// - charging: flash on alarm, trigger charge or button
// - discharging: flash on button with alarm set
// - blink topmost segment only, others steady
// - topmost is lit segment nearest full
// - blink period twice setting, not discharging
// - blink on charge current or button press
// - blink setting zero disables blinking
// - ramp segments upward with step delay
// - step delay zero lights all at once
// - flash setting in 500us units, default 512
// - blink setting in 500us units, default 1024
// - charge source chosen by select bit
// - hold timer after ramp, then display off
// - step delay in 500us units, default 100
`timescale 1ns/1ps
`include "soc_led_params.svh"

module soc_led_display_sequencer
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic display_request_pin_in,
   input wire logic [7:0] absolute_charge_pct_in,
   input wire logic [7:0] relative_charge_pct_in,
   input wire logic [2:0] segment_total_in,
   input wire soc_led_pkg::led_status_t status_in,
   input wire soc_led_pkg::led_timing_t timing_in,
   output logic [`SEG_COUNT-1:0] segment_out,
   output logic display_active_out
);

   // ---------------------------------------------------------------
   // pin synchroniser and falling edge
   // ---------------------------------------------------------------
   logic pin_meta_r, pin_sync_r, pin_prev_r;
   logic pin_meta_nxt, pin_sync_nxt, pin_prev_nxt;
   logic button_fall;

   // first stage feeds only the second stage
   always_comb
   begin
      pin_meta_nxt = display_request_pin_in;
      pin_sync_nxt = pin_meta_r;
      pin_prev_nxt = pin_sync_r;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pin_meta_r <= 1'b1;
         pin_sync_r <= 1'b1;
         pin_prev_r <= 1'b1;
      end
      else
      begin
         pin_meta_r <= pin_meta_nxt;
         pin_sync_r <= pin_sync_nxt;
         pin_prev_r <= pin_prev_nxt;
      end
   end

   assign button_fall = pin_prev_r & ~pin_sync_r;

   // ---------------------------------------------------------------
   // 500 us tick
   // ---------------------------------------------------------------
   localparam logic [15:0] TICK_LAST = 16'(`TICK_CYCLES - 1);
   logic [15:0] tick_cnt_r, tick_cnt_nxt;
   logic tick;

   // one divider so all display timing shares a phase
   always_comb
   begin
      tick = (tick_cnt_r == TICK_LAST);
      tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         tick_cnt_r <= 16'h0000;
      else
         tick_cnt_r <= tick_cnt_nxt;
   end

   // ---------------------------------------------------------------
   // segments required by the charge level
   // ---------------------------------------------------------------
   function automatic logic [2:0] seg_needed(input logic [7:0] pct,
                                             input logic [2:0] total);
      logic [15:0] prod;
      logic [2:0] n;
      prod = 16'(pct) * 16'(total) + 16'd99;
      prod = prod / 16'd100;
      // clamp before narrowing so a reading above 100 cannot wrap
      if (prod > 16'(total))
         prod = 16'(total);
      n = prod[2:0];
      if (n == 3'd0)
         n = 3'd1; // lowest segment stays lit even at zero charge
      return n;
   endfunction

   logic [7:0] soc_pct;
   logic [2:0] target;
   logic [2:0] total_clamped;

   // total clamped to the 3..5 bar sizes supported
   always_comb
   begin
      total_clamped = segment_total_in;
      if (total_clamped < 3'd3)
         total_clamped = 3'd3;
      if (total_clamped > 3'd5)
         total_clamped = 3'd5;
      soc_pct = status_in.soc_source_select ? absolute_charge_pct_in
                                            : relative_charge_pct_in;
      target = seg_needed(soc_pct, total_clamped);
   end

   // ---------------------------------------------------------------
   // activation request decode
   // ---------------------------------------------------------------
   logic charge_req, alarm_on, flash_req, blink_req, start_req;

   always_comb
   begin
      charge_req = ~status_in.discharging & status_in.charge_display_enable
                   & status_in.charge_above_thresh;
      alarm_on = status_in.alarm_flash_enable
                 & status_in.remaining_capacity_alarm;
      start_req = button_fall | charge_req;
      flash_req = alarm_on & (button_fall
                  | (~status_in.discharging
                     & status_in.charge_display_enable));
      blink_req = ~status_in.discharging
                  & (charge_req | button_fall);
   end

   // ---------------------------------------------------------------
   // display sequencer
   // ---------------------------------------------------------------
   soc_led_pkg::display_request_pin_state_t state_r, state_nxt;
   logic [2:0] lit_r, lit_nxt;
   logic [15:0] wait_r, wait_nxt;
   logic flash_mode_r, flash_mode_nxt;
   logic blink_mode_r, blink_mode_nxt;

   // a new request during hold only adds flash or blink mode; the lit count and hold timer carry on
   always_comb
   begin
      state_nxt = state_r;
      lit_nxt = lit_r;
      wait_nxt = wait_r;
      flash_mode_nxt = flash_mode_r;
      blink_mode_nxt = blink_mode_r;
      case (state_r)
         soc_led_pkg::ST_IDLE:
         begin
            if (start_req)
            begin
               flash_mode_nxt = flash_req;
               blink_mode_nxt = blink_req;
               wait_nxt = 16'h0000;
               if (timing_in.segment_step_delay == 16'h0000)
               begin
                  lit_nxt = target;
                  state_nxt = soc_led_pkg::ST_HOLD;
               end
               else
               begin
                  lit_nxt = 3'd1;
                  state_nxt = (target == 3'd1) ? soc_led_pkg::ST_HOLD
                                               : soc_led_pkg::ST_RAMP;
               end
            end
         end
         soc_led_pkg::ST_RAMP:
         begin
            if (tick)
            begin
               if (wait_r + 16'h0001 >= timing_in.segment_step_delay)
               begin
                  wait_nxt = 16'h0000;
                  lit_nxt = lit_r + 3'd1;
                  if (lit_r + 3'd1 >= target)
                     state_nxt = soc_led_pkg::ST_HOLD;
               end
               else
                  wait_nxt = wait_r + 16'h0001;
            end
         end
         soc_led_pkg::ST_HOLD:
         begin
            if (start_req)
            begin
               flash_mode_nxt = flash_mode_r | flash_req;
               blink_mode_nxt = blink_mode_r | blink_req;
            end
            if (tick)
            begin
               if (wait_r + 16'h0001 >= timing_in.display_hold_time)
               begin
                  wait_nxt = 16'h0000;
                  lit_nxt = 3'd0;
                  flash_mode_nxt = 1'b0;
                  blink_mode_nxt = 1'b0;
                  state_nxt = soc_led_pkg::ST_IDLE;
               end
               else
                  wait_nxt = wait_r + 16'h0001;
            end
         end
         default:
         begin
            state_nxt = soc_led_pkg::ST_IDLE;
            lit_nxt = 3'd0;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_r <= soc_led_pkg::ST_IDLE;
         lit_r <= 3'd0;
         wait_r <= 16'h0000;
         flash_mode_r <= 1'b0;
         blink_mode_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         lit_r <= lit_nxt;
         wait_r <= wait_nxt;
         flash_mode_r <= flash_mode_nxt;
         blink_mode_r <= blink_mode_nxt;
      end
   end

   // ---------------------------------------------------------------
   // flash and blink phase counters
   // ---------------------------------------------------------------
   logic [15:0] flash_cnt_r, flash_cnt_nxt, blink_cnt_r, blink_cnt_nxt;
   logic flash_ph_r, flash_ph_nxt, blink_ph_r, blink_ph_nxt;

   // each phase toggles every half period, giving 50% duty
   always_comb
   begin
      flash_cnt_nxt = flash_cnt_r;
      flash_ph_nxt = flash_ph_r;
      blink_cnt_nxt = blink_cnt_r;
      blink_ph_nxt = blink_ph_r;
      if (state_r == soc_led_pkg::ST_IDLE)
      begin
         flash_cnt_nxt = 16'h0000;
         flash_ph_nxt = 1'b1;
         blink_cnt_nxt = 16'h0000;
         blink_ph_nxt = 1'b1;
      end
      else if (tick)
      begin
         if (flash_cnt_r + 16'h0001 >= timing_in.flash_half_period)
         begin
            flash_cnt_nxt = 16'h0000;
            flash_ph_nxt = ~flash_ph_r;
         end
         else
            flash_cnt_nxt = flash_cnt_r + 16'h0001;
         if (blink_cnt_r + 16'h0001 >= timing_in.blink_half_period)
         begin
            blink_cnt_nxt = 16'h0000;
            blink_ph_nxt = ~blink_ph_r;
         end
         else
            blink_cnt_nxt = blink_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         flash_cnt_r <= 16'h0000;
         flash_ph_r <= 1'b1;
         blink_cnt_r <= 16'h0000;
         blink_ph_r <= 1'b1;
      end
      else
      begin
         flash_cnt_r <= flash_cnt_nxt;
         flash_ph_r <= flash_ph_nxt;
         blink_cnt_r <= blink_cnt_nxt;
         blink_ph_r <= blink_ph_nxt;
      end
   end

   // ---------------------------------------------------------------
   // segment drive
   // ---------------------------------------------------------------
   logic [`SEG_COUNT-1:0] seg_nxt, seg_r;
   logic blink_on;

   // flash has priority over blink when both are requested
   always_comb
   begin
      blink_on = blink_mode_r & ~status_in.discharging
                 & (timing_in.blink_half_period != 16'h0000);
      seg_nxt = '0;
      for (int i = 0; i < `SEG_COUNT; i++)
      begin
         if (3'(i) < lit_r)
         begin
            if (flash_mode_r)
               seg_nxt[i] = flash_ph_r;
            else if (blink_on && (3'(i) == lit_r - 3'd1))
               seg_nxt[i] = blink_ph_r;
            else
               seg_nxt[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         seg_r <= '0;
      else
         seg_r <= seg_nxt;
   end

   assign segment_out = seg_r;
   assign display_active_out = (state_r != soc_led_pkg::ST_IDLE);

endmodule

// ### soc_led_display_sequencer_asserts.sv
// concurrent checks on the led display sequencer ports
`timescale 1ns/1ps
`include "soc_led_params.svh"
module soc_led_display_sequencer_asserts
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic display_request_pin_in,
   input wire logic [7:0] absolute_charge_pct_in,
   input wire logic [7:0] relative_charge_pct_in,
   input wire logic [2:0] segment_total_in,
   input wire soc_led_pkg::led_status_t status_in,
   input wire soc_led_pkg::led_timing_t timing_in,
   input wire logic [`SEG_COUNT-1:0] segment_out,
   input wire logic display_active_out
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   logic [2:0] seg_lim;
   logic no_flash;
   // bar size clamped to 3..5 the same way the sequencer clamps it
   assign seg_lim = (segment_total_in < 3'h3) ? 3'h3 :
      (segment_total_in > 3'h5) ? 3'h5 : segment_total_in;
   assign no_flash = !(status_in.alarm_flash_enable &&
      status_in.remaining_capacity_alarm);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence btn_fall;
      !display_active_out ##1 $fell(display_request_pin_in);
   endsequence
   sequence act_start;
      !display_active_out ##1 display_active_out;
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   AST_RESET_DARK: assert property (disable iff (1'b0)
      rst_in |-> segment_out == 5'h00 && !display_active_out)
      else $error("outputs not cleared in reset");
   AST_BTN_START: assert property (
      btn_fall |-> ##[1:6] display_active_out)
      else $error("button press not answered");
   AST_FIRST_SEG: assert property (
      act_start |=> segment_out[0])
      else $error("lowest segment not lit first");
   AST_IDLE_DARK: assert property (
      !display_active_out [*2] |-> segment_out == 5'h00)
      else $error("segments lit while idle");
   AST_CONTIG: assert property (
      (segment_out & (segment_out + 5'h01)) == 5'h00)
      else $error("segments not contiguous from the bottom");
   AST_BOUND: assert property (
      (segment_out >> seg_lim) == 5'h00)
      else $error("segment above bar size lit");
   AST_SPACING: assert property (
      $changed(segment_out) && $past(segment_out) != 5'h00 &&
      display_active_out |=>
      (!$changed(segment_out) || !display_active_out) [*8])
      else $error("segment change faster than the tick");
   AST_DSG_STEADY: assert property (
      display_active_out && $past(display_active_out) &&
      status_in.discharging && no_flash |->
      segment_out >= $past(segment_out))
      else $error("segment dropped while discharging");
endmodule

bind soc_led_display_sequencer soc_led_display_sequencer_asserts u_asserts
(
   .clk_in(clk_in),
   .rst_in(rst_in),
   .display_request_pin_in(display_request_pin_in),
   .absolute_charge_pct_in(absolute_charge_pct_in),
   .relative_charge_pct_in(relative_charge_pct_in),
   .segment_total_in(segment_total_in),
   .status_in(status_in),
   .timing_in(timing_in),
   .segment_out(segment_out),
   .display_active_out(display_active_out)
);

// ### soc_led_panel.sv
// push-button model standing at the display request pin
`timescale 1ns/1ps
module soc_led_panel
(
   input wire logic clk_in,
   input wire logic press_in,
   output logic pin_out
);
   int low_r = 0;
   // held low a few cycles so the two-flop sync sees it
   always @(posedge clk_in)
   begin
      if (press_in)
         low_r <= 6;
      else if (low_r > 0)
         low_r <= low_r - 1;
   end
   assign pin_out = (low_r == 0); // released pin rests at the pull-up
endmodule

// ### soc_led_display_sequencer_tb.sv
// self-checking bench for the led display sequencer
`timescale 1ns/1ps
`include "soc_led_params.svh"
module soc_led_display_sequencer_tb;
   logic clk_in = 1'b0;
   logic rst_in;
   logic press = 1'b0;
   logic pin;
   logic [7:0] abs_pct = 8'h00;
   logic [7:0] rel_pct = 8'h00;
   logic [2:0] total = 3'h5;
   soc_led_pkg::led_status_t status = '0;
   soc_led_pkg::led_timing_t timing = '0;
   logic [`SEG_COUNT-1:0] segment_out;
   logic display_active_out;
   logic [`SEG_COUNT-1:0] expect_q[$];
   logic [`SEG_COUNT-1:0] last_seg = 5'h00;
   logic [15:0] lfsr_r = 16'h4717; // seed 18199
   int fails = 0;
   int checked = 0;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [4:0] mask(input int n);
      return 5'((32'h1 << n) - 1);
   endfunction
   task automatic check(input logic [4:0] seen, input logic [4:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: seg %h want %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (fails == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one button-driven display; the unused source gets noise
   task automatic show(input logic sel, input logic [7:0] pct,
      input logic [2:0] tot, input logic [15:0] step, input logic dsg,
      input logic [15:0] blink);
      int n;
      int k;
      n = (pct * tot + 99) / 100;
      if (n < 1)
         n = 1;
      if (n > tot)
         n = tot;
      @(posedge clk_in);
      lfsr_r <= lfsr_next(lfsr_r);
      status.soc_source_select <= sel;
      status.discharging <= dsg;
      abs_pct <= sel ? pct : lfsr_r[7:0];
      rel_pct <= sel ? lfsr_r[15:8] : pct;
      total <= tot;
      timing.segment_step_delay <= step;
      timing.blink_half_period <= blink;
      if (step == 16'h0000)
         expect_q.push_back(mask(n));
      else
         for (k = 1; k <= n; k++)
            expect_q.push_back(mask(k));
      expect_q.push_back(5'h00);
      @(posedge clk_in);
      press <= 1'b1;
      @(posedge clk_in);
      press <= 1'b0;
      k = 0;
      while (display_active_out !== 1'b1 && k < 50)
      begin
         @(posedge clk_in);
         k++;
      end
      while (display_active_out !== 1'b0 && k < 120000)
      begin
         @(posedge clk_in);
         k++;
      end
      repeat (4) @(posedge clk_in);
      if (expect_q.size() != 0)
      begin
         fails++;
         $display("wrong value at %0t: display ended early", $time);
      end
   endtask
   // ----------------------------------------
   // structure and processes
   // ----------------------------------------
   soc_led_panel u_panel
   (
      .clk_in(clk_in),
      .press_in(press),
      .pin_out(pin)
   );
   soc_led_display_sequencer u_dut
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .display_request_pin_in(pin),
      .absolute_charge_pct_in(abs_pct),
      .relative_charge_pct_in(rel_pct),
      .segment_total_in(total),
      .status_in(status),
      .timing_in(timing),
      .segment_out(segment_out),
      .display_active_out(display_active_out)
   );
   initial
   begin
      forever #10 clk_in = ~clk_in;
   end
   // every change of the bar is matched against the oldest note
   always @(posedge clk_in)
   begin
      #1;
      if (segment_out !== last_seg)
      begin
         last_seg = segment_out;
         if (expect_q.size() == 0)
         begin
            fails++;
            $display("wrong value at %0t: stray segment change", $time);
         end
         else
            check(segment_out, expect_q.pop_front());
      end
   end
   // tick is fixed, so two displays bound the whole run
   initial
   begin
      #(20 * 200000);
      fails++;
      close_out();
   end
   initial
   begin
      // late in time zero so the async reset sees a real rising edge
      rst_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      rst_in <= 1'b0;
      timing <= {16'h0001, 16'h0000, 16'h0000, 16'h0001};
      repeat (2) @(posedge clk_in);
      show(1'b0, 8'(lfsr_r % 101), 3'h5, 16'h0000, 1'b0, 16'h0000);
      show(1'b1, 8'h28, 3'h3, 16'h0001, 1'b1, 16'h0001);
      close_out();
   end
endmodule
